// ==== verif/port_config_and_irq_output_monitor.sv ====
`default_nettype none
module port_config_and_irq_output_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic link_clock,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [15:0] port_in,
   input wire logic [15:0] port_direction_bit,
   input wire logic blink_enable,
   input wire logic blink_phase_sel,
   input wire logic global_intensity_sel,
   input wire logic extra_pin_master_intensity,
   input wire logic change_flag,
   input wire logic irq_or_gpo_pin_out,
   input wire logic irq_or_gpo_pin_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] quiet_q;

   // Cycles since pins or directions last moved, saturating; a frozen core restarts it
   always_ff @(posedge clock) begin
      if (rst || !ce || $changed(port_in) || $changed(port_direction_bit)) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end

   // Every port an output for a while
   sequence s_all_out;
      (port_direction_bit == 16'h0000) [*5];
   endsequence

   property p_phase;
      @(posedge clock) disable iff (rst) blink_phase_sel |-> blink_enable;
   endproperty
   property p_master;
      @(posedge clock) disable iff (rst) extra_pin_master_intensity;
   endproperty
   property p_rst;
      @(posedge clock) disable iff (rst) $fell(rst) |-> port_direction_bit == 16'hFFFF
         && global_intensity_sel && !blink_enable && !irq_or_gpo_pin_oe;
   endproperty
   property p_cause;
      @(posedge clock) disable iff (rst) $rose(change_flag)
         |-> (quiet_q < 4'h8) || $changed(port_direction_bit);
   endproperty
   property p_mask;
      @(posedge clock) disable iff (rst) s_all_out |-> !change_flag;
   endproperty
   property p_pin0;
      @(posedge clock) disable iff (rst) !irq_or_gpo_pin_out;
   endproperty
   property p_sda0;
      @(posedge link_clock) disable iff (rst) !sda_out;
   endproperty
   // Data line only gets pulled low while the serial clock is low
   property p_ack;
      @(posedge link_clock) disable iff (rst) $rose(sda_oe) |-> !$past(scl_in);
   endproperty

   a_phase: assert property (p_phase) else $error("phase select without blink");
   a_master: assert property (p_master) else $error("extra pin not on master");
   a_rst: assert property (p_rst) else $error("bad values after reset");
   a_cause: assert property (p_cause) else $error("flag rose without a change");
   a_mask: assert property (p_mask) else $error("flag with no input ports");
   a_pin0: assert property (p_pin0) else $error("extra pin driven high");
   a_sda0: assert property (p_sda0) else $error("data line driven high");
   a_ack: assert property (p_ack) else $error("data pulled with clock high");
endmodule

bind port_config_and_irq_output port_config_and_irq_output_monitor i_mon (
   .clock(clock), .rst(rst), .ce(ce), .link_clock(link_clock), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .port_in(port_in),
   .port_direction_bit(port_direction_bit), .blink_enable(blink_enable),
   .blink_phase_sel(blink_phase_sel), .global_intensity_sel(global_intensity_sel),
   .extra_pin_master_intensity(extra_pin_master_intensity),
   .change_flag(change_flag), .irq_or_gpo_pin_out(irq_or_gpo_pin_out),
   .irq_or_gpo_pin_oe(irq_or_gpo_pin_oe));
`default_nettype wire

// ==== verif/port_config_and_irq_output_test.sv ====
`default_nettype none
module port_config_and_irq_output_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [47:0] CASES = 48'h231315211022;
   logic clock, rst, ce, link_clock, scl_line, sda_line, sda_oe, exp_oe;
   logic blink_enable, blink_phase_sel, global_sel, master_sel, change_flag, pin_oe;
   logic [15:0] port_in, dir;
   logic [7:0] rd_q, c;
   int n_mismatch, n_compared;

   always #2.5 clock = ~clock;

   // Link clock offset so its edges never line up with the core
   initial begin
      link_clock = 1'b0;
      #13.3;
      forever #40 link_clock = ~link_clock;
   end

   port_config_and_irq_output i_dut (.clock(clock), .rst(rst), .ce(ce),
      .link_clock(link_clock), .scl_in(scl_line), .sda_in(sda_line), .sda_out(),
      .sda_oe(sda_oe), .port_in(port_in), .port_direction_bit(dir),
      .blink_enable(blink_enable), .blink_phase_sel(blink_phase_sel),
      .global_intensity_sel(global_sel), .extra_pin_master_intensity(master_sel),
      .change_flag(change_flag), .irq_or_gpo_pin_out(), .irq_or_gpo_pin_oe(pin_oe));

   serial_host_model i_host (.link_clock(link_clock), .sda_oe(sda_oe),
      .scl_line(scl_line), .sda_line(sda_line));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Pins move on the falling edge, then let the syncs catch up
   task automatic pins(input logic [15:0] v);
      @(negedge clock);
      port_in = v;
      repeat (20) @(negedge clock);
   endtask

   initial begin
      #450000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      port_in = 16'h0000;
      n_mismatch = 0;
      n_compared = 0;
      // Long enough for the link side reset as well
      repeat (64) @(negedge clock);
      rst = 1'b0;
      repeat (80) @(negedge clock);
      check("dir", dir, 16'hFFFF);
      check("sel", {blink_phase_sel, blink_enable, global_sel, master_sel}, 4'h3);
      check("pin", pin_oe, 1'b0);
      i_host.rd(8'h0F, rd_q);
      check("cfg", rd_q, 8'h0C);
      i_host.rd(8'h06, rd_q);
      check("dir_lo", rd_q, 8'hFF);
      i_host.rd(8'h07, rd_q);
      check("dir_hi", rd_q, 8'hFF);
      // Top two bits must not stick
      i_host.wr(7'h20, 8'h0F, 8'hFF);
      check("ack", i_host.ack_seen, 1'b1);
      i_host.rd(8'h0F, rd_q);
      check("cfg", rd_q, 8'h3F);
      check("sel", {blink_phase_sel, blink_enable, global_sel}, 3'h7);
      check("pin", pin_oe, 1'b0);
      // Extra pin as plain output, every blink mode
      for (int i = 0; i < 6; i++) begin
         c = CASES[8*i +: 8];
         i_host.wr(7'h20, 8'h0F, c);
         exp_oe = (c[0] && c[1]) ? ~c[5] : ~c[4];
         check("pin", pin_oe, exp_oe);
         check("blink", {blink_phase_sel, blink_enable}, {c[0] & c[1], c[0]});
         check("global", global_sel, c[2]);
      end
      // Wrong device address leaves everything alone
      i_host.wr(7'h21, 8'h0F, 8'h00);
      check("nack", i_host.ack_seen, 1'b0);
      check("pin", pin_oe, 1'b0);
      i_host.rd(8'h30, rd_q);
      check("unmapped", rd_q, 8'h00);
      i_host.wr(7'h20, 8'h06, 8'h00);
      i_host.wr(7'h20, 8'h07, 8'h00);
      check("dir", dir, 16'h0000);
      pins(16'hFFFF);
      check("flag", change_flag, 1'b0);
      pins(16'h0000);
      i_host.wr(7'h20, 8'h06, 8'h5A);
      i_host.wr(7'h20, 8'h07, 8'h3C);
      check("dir", dir, 16'h3C5A);
      i_host.rd(8'h06, rd_q);
      check("dir_lo", rd_q, 8'h5A);
      i_host.rd(8'h07, rd_q);
      check("dir_hi", rd_q, 8'h3C);
      // Change detection on input port 1; port 0 is an output
      i_host.wr(7'h20, 8'h0F, 8'h08);
      pins(16'h0002);
      check("flag", {change_flag, pin_oe}, 2'b11);
      i_host.rd(8'h0F, rd_q);
      check("cfg", rd_q, 8'h88);
      pins(16'h0000);
      check("flag", {change_flag, pin_oe}, 2'b00);
      pins(16'h0002);
      i_host.wr(7'h20, 8'h0F, 8'h08);
      check("flag", change_flag, 1'b0);
      pins(16'h0003);
      check("flag", change_flag, 1'b0);
      pins(16'h0001);
      check("flag", change_flag, 1'b1);
      i_host.rd(8'h00, rd_q);
      repeat (20) @(negedge clock);
      check("flag", change_flag, 1'b0);
      // Frozen core holds the flag until the enable returns
      ce = 1'b0;
      pins(16'h0003);
      check("frozen", change_flag, 1'b0);
      ce = 1'b1;
      repeat (20) @(negedge clock);
      check("flag", change_flag, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire

// ==== verif/serial_host_model.sv ====
`default_nettype none
module serial_host_model (
   input wire logic link_clock,
   input wire logic sda_oe,
   output logic scl_line,
   output logic sda_line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pull_q;
   logic ack_seen;

   // Pull-up on the wire: high unless someone pulls
   assign sda_line = ~(pull_q | sda_oe);

   initial begin
      scl_line = 1'b1;
      pull_q = 1'b0;
      ack_seen = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge link_clock);
   endtask

   // Data moves mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic seen);
      scl_line = 1'b0;
      tick(2);
      pull_q = ~b;
      tick(2);
      scl_line = 1'b1;
      tick(1);
      seen = sda_line;
      tick(1);
   endtask

   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, s);
      ack_seen = ack_seen & ~s;
   endtask

   // Also serves as repeated start
   task automatic start();
      scl_line = 1'b0;
      tick(2);
      pull_q = 1'b0;
      tick(2);
      scl_line = 1'b1;
      tick(2);
      pull_q = 1'b1;
      tick(2);
   endtask

   task automatic stop();
      scl_line = 1'b0;
      tick(2);
      pull_q = 1'b1;
      tick(2);
      scl_line = 1'b1;
      tick(2);
      pull_q = 1'b0;
      tick(2);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
      logic [7:0] q;
      ack_seen = 1'b1;
      start();
      xfer({a, 1'b0}, 1'b1, q);
      xfer(p, 1'b1, q);
      xfer(d, 1'b1, q);
      stop();
   endtask

   // Pointer write, repeated start, one byte, then refuse more
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] q;
      logic a;
      ack_seen = 1'b1;
      start();
      xfer(8'h40, 1'b1, q);
      xfer(p, 1'b1, q);
      start();
      xfer(8'h41, 1'b1, q);
      a = ack_seen;
      xfer(8'hFF, 1'b1, d);
      ack_seen = a;
      stop();
   endtask
endmodule
`default_nettype wire

// ==== verilog/port_config_and_irq_output.sv ====
`include "port_config_regs.svh"
`default_nettype none

// Function
// - D0 enables blink, D1 picks phase
// - D2 set: all outputs use master intensity
// - D2 clear: per-port intensity, extra pin master
// - D3 set: extra pin shows change flag
// - D3 clear: extra pin is GPO from D4/D5
// - No blink: D4 low pulls low, else float
// - Blink phase 0: D4 sets pin level
// - Blink phase 1: D5 sets pin level
// - D7 reads change flag; pin low while set if D3 set
// - D6 reads zero, rest as written
// - Direction bit per port, one means input
// - Direction registers read back at their addresses
// - Configuration write resamples change reference
// - Flag clears on return or on a read of each input byte that changed
module port_config_and_irq_output
   import port_config_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDRESS = `SLAVE_ADDRESS_DEFAULT
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic link_clock,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [15:0] port_in,
   output logic [15:0] port_direction_bit,
   output logic blink_enable,
   output logic blink_phase_sel,
   output logic global_intensity_sel,
   output logic extra_pin_master_intensity,
   output logic change_flag,
   output logic irq_or_gpo_pin_out,
   output logic irq_or_gpo_pin_oe
);

   // Link domain reset, brought over from the core reset
   logic lrst_1_q, lrst_q;
   // Pin synchronisers on the link clock
   logic scl_1_q, scl_2_q, scl_3_q;
   logic sda_1_q, sda_2_q, sda_3_q;
   logic [15:0] lport_1_q, lport_2_q;
   logic lflag_1_q, lflag_2_q;
   // Serial slave
   serial_state_type state_q;
   logic [3:0] bit_count_q;
   logic [7:0] shift_q, pointer_q, write_addr_q, write_data_q, read_addr_q;
   logic read_not_write_q, master_ack_q, sda_oe_q, write_strobe_q, read_strobe_q;
   // Link side registers
   logic [15:0] direction_q;
   config_type config_q;
   logic config_write_toggle_q, input_low_toggle_q, input_high_toggle_q;
   // Core domain crossings
   logic [15:0] cdir_1_q, cdir_2_q, cport_1_q, cport_2_q;
   config_type ccfg_1_q, ccfg_2_q;
   logic [2:0] ctgl_1_q, ctgl_2_q, ctgl_3_q;
   // Change detection
   logic [15:0] reference_q;
   logic init_pending_q, flag_q, extra_oe_q;
   // Combinational
   logic start_seen, stop_seen, scl_rise, scl_fall, load_read, extra_drive_low;
   logic [7:0] read_byte, next_pointer;
   logic [2:0] toggle_events;

   // Plain two-flop bring-over of the core reset
   always_ff @(posedge link_clock) begin
      lrst_1_q <= rst;
      lrst_q <= lrst_1_q;
   end

   // Pins and the flag pass two flops before the slave looks at them
   always_ff @(posedge link_clock) begin
      scl_1_q <= scl_in;
      scl_2_q <= scl_1_q;
      scl_3_q <= scl_2_q;
      sda_1_q <= sda_in;
      sda_2_q <= sda_1_q;
      sda_3_q <= sda_2_q;
      lport_1_q <= port_in;
      lport_2_q <= lport_1_q;
      lflag_1_q <= flag_q;
      lflag_2_q <= lflag_1_q;
   end

   // Bus conditions from the synchronised pins
   assign start_seen = scl_2_q && scl_3_q && sda_3_q && !sda_2_q;
   assign stop_seen = scl_2_q && scl_3_q && !sda_3_q && sda_2_q;
   assign scl_rise = scl_2_q && !scl_3_q;
   assign scl_fall = !scl_2_q && scl_3_q;

   // Read mux; unmapped pointers read as zero
   always_comb begin
      case (pointer_q)
         `REG_INPUT_LOW: read_byte = lport_2_q[7:0];
         `REG_INPUT_HIGH: read_byte = lport_2_q[15:8];
         `REG_DIRECTION_LOW: read_byte = direction_q[7:0];
         `REG_DIRECTION_HIGH: read_byte = direction_q[15:8];
         // flag on top, fixed zero below
         `REG_CONFIGURATION: read_byte = {lflag_2_q, 1'b0, config_q};
         default: read_byte = `READ_UNMAPPED;
      endcase
   end

   // Pairs swap, configuration stays put
   always_comb begin
      case (pointer_q)
         `REG_INPUT_LOW: next_pointer = `REG_INPUT_HIGH;
         `REG_INPUT_HIGH: next_pointer = `REG_INPUT_LOW;
         `REG_DIRECTION_LOW: next_pointer = `REG_DIRECTION_HIGH;
         `REG_DIRECTION_HIGH: next_pointer = `REG_DIRECTION_LOW;
         default: next_pointer = pointer_q;
      endcase
   end

   // Load a read byte after the address ack or an acked byte
   assign load_read = scl_fall && ((state_q == ST_ADDR_ACK && read_not_write_q) ||
                                   (state_q == ST_READ_ACK && master_ack_q));

   // Serial slave: sample on rising SCL, change SDA on falling SCL
   always_ff @(posedge link_clock) begin
      if (lrst_q) begin
         state_q <= ST_IDLE;
         bit_count_q <= 4'h0;
         shift_q <= 8'h00;
         pointer_q <= 8'h00;
         read_not_write_q <= 1'b0;
         master_ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         write_strobe_q <= 1'b0;
         write_addr_q <= 8'h00;
         write_data_q <= 8'h00;
         read_strobe_q <= 1'b0;
         read_addr_q <= 8'h00;
      end else begin
         write_strobe_q <= 1'b0;
         read_strobe_q <= 1'b0;
         if (start_seen) begin
            state_q <= ST_ADDR;
            bit_count_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (stop_seen) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else if (scl_rise) begin
            case (state_q)
               ST_ADDR, ST_POINTER, ST_WRITE_DATA: begin
                  shift_q <= {shift_q[6:0], sda_2_q};
                  bit_count_q <= bit_count_q + 4'h1;
               end
               ST_READ_DATA: bit_count_q <= bit_count_q + 4'h1;
               ST_READ_ACK: master_ack_q <= !sda_2_q;
               default: begin
               end
            endcase
         end else if (load_read) begin
            shift_q <= read_byte;
            sda_oe_q <= !read_byte[7];
            read_strobe_q <= 1'b1;
            read_addr_q <= pointer_q;
            pointer_q <= next_pointer;
            bit_count_q <= 4'h0;
            state_q <= ST_READ_DATA;
         end else if (scl_fall) begin
            case (state_q)
               ST_ADDR: begin
                  if (bit_count_q == `SERIAL_BITS) begin
                     if (shift_q[7:1] == SLAVE_ADDRESS) begin
                        read_not_write_q <= shift_q[0];
                        sda_oe_q <= 1'b1;
                        state_q <= ST_ADDR_ACK;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  sda_oe_q <= 1'b0;
                  bit_count_q <= 4'h0;
                  state_q <= ST_POINTER;
               end
               ST_POINTER: begin
                  if (bit_count_q == `SERIAL_BITS) begin
                     pointer_q <= shift_q;
                     sda_oe_q <= 1'b1;
                     state_q <= ST_POINTER_ACK;
                  end
               end
               ST_POINTER_ACK, ST_WRITE_ACK: begin
                  sda_oe_q <= 1'b0;
                  bit_count_q <= 4'h0;
                  state_q <= ST_WRITE_DATA;
               end
               ST_WRITE_DATA: begin
                  if (bit_count_q == `SERIAL_BITS) begin
                     write_strobe_q <= 1'b1;
                     write_addr_q <= pointer_q;
                     write_data_q <= shift_q;
                     pointer_q <= next_pointer;
                     sda_oe_q <= 1'b1;
                     state_q <= ST_WRITE_ACK;
                  end
               end
               ST_READ_DATA: begin
                  if (bit_count_q == `SERIAL_BITS) begin
                     sda_oe_q <= 1'b0;
                     state_q <= ST_READ_ACK;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sda_oe_q <= !shift_q[6];
                  end
               end
               ST_READ_ACK: state_q <= ST_IDLE; // Master said no more
               ST_IDLE: begin
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Link side register file and event toggles
   always_ff @(posedge link_clock) begin
      if (lrst_q) begin
         direction_q <= {`DIRECTION_RESET, `DIRECTION_RESET};
         config_q <= `CONFIG_RESET;
         config_write_toggle_q <= 1'b0;
         input_low_toggle_q <= 1'b0;
         input_high_toggle_q <= 1'b0;
      end else begin
         if (write_strobe_q) begin
            case (write_addr_q)
               `REG_DIRECTION_LOW: direction_q[7:0] <= write_data_q;
               `REG_DIRECTION_HIGH: direction_q[15:8] <= write_data_q;
               `REG_CONFIGURATION: begin
                  config_q <= write_data_q[`CFG_STORED_BITS-1:0];
                  config_write_toggle_q <= !config_write_toggle_q;
               end
               default: begin
               end
            endcase
         end
         if (read_strobe_q && read_addr_q == `REG_INPUT_LOW) begin
            input_low_toggle_q <= !input_low_toggle_q;
         end
         if (read_strobe_q && read_addr_q == `REG_INPUT_HIGH) begin
            input_high_toggle_q <= !input_high_toggle_q;
         end
      end
   end

   // Settings change rarely; a bit skew for one cycle is tolerated
   always_ff @(posedge clock) begin
      if (ce) begin
         cdir_1_q <= direction_q;
         cdir_2_q <= cdir_1_q;
         ccfg_1_q <= config_q;
         ccfg_2_q <= ccfg_1_q;
         ctgl_1_q <= {input_high_toggle_q, input_low_toggle_q, config_write_toggle_q};
         ctgl_2_q <= ctgl_1_q;
         ctgl_3_q <= ctgl_2_q;
         cport_1_q <= port_in;
         cport_2_q <= cport_1_q;
      end
   end

   assign toggle_events = ctgl_2_q ^ ctgl_3_q;

   // Reference sampled once after reset so idle inputs raise nothing
   always_ff @(posedge clock) begin
      if (rst) begin
         reference_q <= 16'h0000;
         init_pending_q <= 1'b1;
      end else if (ce) begin
         init_pending_q <= 1'b0;
         if (init_pending_q || toggle_events[0]) begin
            reference_q <= cport_2_q;
         end else begin
            if (toggle_events[1]) begin
               reference_q[7:0] <= cport_2_q[7:0];
            end
            if (toggle_events[2]) begin
               reference_q[15:8] <= cport_2_q[15:8];
            end
         end
      end
   end

   // flag follows the compare, so it clears on return
   always_ff @(posedge clock) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         flag_q <= !init_pending_q && |((cport_2_q ^ reference_q) & cdir_2_q);
      end
   end

   // Extra pin: open drain, so only low or released
   always_comb begin
      if (ccfg_2_q.irq_enable) begin
         extra_drive_low = flag_q;
      end else if (!ccfg_2_q.blink_enable) begin
         extra_drive_low = !ccfg_2_q.gpo_level_phase0;
      end else if (!ccfg_2_q.blink_flip) begin
         extra_drive_low = !ccfg_2_q.gpo_level_phase0;
      end else begin
         extra_drive_low = !ccfg_2_q.gpo_level_phase1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         extra_oe_q <= 1'b0;
      end else if (ce) begin
         extra_oe_q <= extra_drive_low && !init_pending_q;
      end
   end

   // static controls to the engines, each a flop output
   always_ff @(posedge clock) begin
      if (rst) begin
         port_direction_bit <= {`DIRECTION_RESET, `DIRECTION_RESET};
         blink_enable <= 1'b0;
         blink_phase_sel <= 1'b0;
         global_intensity_sel <= 1'b1;
         extra_pin_master_intensity <= 1'b1;
      end else if (ce) begin
         port_direction_bit <= cdir_2_q;
         blink_enable <= ccfg_2_q.blink_enable;
         blink_phase_sel <= ccfg_2_q.blink_enable && ccfg_2_q.blink_flip;
         global_intensity_sel <= ccfg_2_q.global_intensity;
         extra_pin_master_intensity <= 1'b1;
      end
   end

   assign change_flag = flag_q;
   assign irq_or_gpo_pin_out = 1'b0;
   assign irq_or_gpo_pin_oe = extra_oe_q;
   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_q;

endmodule
`default_nettype wire

// ==== verilog/port_config_pkg.sv ====
`default_nettype none
package port_config_pkg;

   // Stored configuration bits, D5 down to D0
   typedef struct packed {
      logic gpo_level_phase1;
      logic gpo_level_phase0;
      logic irq_enable;
      logic global_intensity;
      logic blink_flip;
      logic blink_enable;
   } config_type;

   // Serial slave states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_POINTER = 9'h008,
      ST_POINTER_ACK = 9'h010,
      ST_WRITE_DATA = 9'h020,
      ST_WRITE_ACK = 9'h040,
      ST_READ_DATA = 9'h080,
      ST_READ_ACK = 9'h100
   } serial_state_type;

endpackage
`default_nettype wire

// ==== verilog/port_config_regs.svh ====
`ifndef PORT_CONFIG_REGS_SVH
`define PORT_CONFIG_REGS_SVH

// Register pointer values
`define REG_INPUT_LOW 8'h00
`define REG_INPUT_HIGH 8'h01
`define REG_DIRECTION_LOW 8'h06
`define REG_DIRECTION_HIGH 8'h07
`define REG_CONFIGURATION 8'h0F

// Reset values
`define DIRECTION_RESET 8'hFF
`define CONFIG_RESET 6'h0C
`define READ_UNMAPPED 8'h00

// Configuration field positions
`define CFG_BLINK_ENABLE 0
`define CFG_BLINK_FLIP 1
`define CFG_GLOBAL 2
`define CFG_IRQ_ENABLE 3
`define CFG_GPO_PHASE0 4
`define CFG_GPO_PHASE1 5
`define CFG_STORED_BITS 6

// Serial framing
`define SERIAL_BITS 4'h8
`define SLAVE_ADDRESS_DEFAULT 7'h20

`endif
